/* hdl/fsirq_params.svh */
// Offsets, field positions, reset values and timing counts of the fault/status block
`ifndef FSIRQ_PARAMS_SVH
`define FSIRQ_PARAMS_SVH

// Register indices; the APB byte address is four times the index
`define IDX_THERM_SUPPLY 10'h04F
`define IDX_THERM_BROWN 10'h050
`define IDX_CLK_ERR 10'h051
`define IDX_LOW_CONV_HI 10'h052
`define IDX_LOW_CONV_LO 10'h053
`define IDX_HIGH_CONV_HI 10'h054
`define IDX_HIGH_CONV_LO 10'h055
`define IDX_TEMP_CONV 10'h056
`define IDX_HALT_CTRL 10'h05C
`define IDX_PIN_POL 10'h05D
`define IDX_RATIO 10'h060

// Reset values of the writable registers
`define RST_HALT_CTRL 8'h19
`define RST_PIN_POL 8'h80
`define RST_RATIO 8'h0D

// Field positions in the clock/interrupt control register and the pin polarity register
`define CTRL_AUTO_PWR 7
`define CTRL_HALT_OFF 6
`define CTRL_TMO_HI 5
`define CTRL_TMO_LO 3
`define CTRL_CLR 2
`define CTRL_MODE_HI 1
`define CTRL_MODE_LO 0
`define POL_LEVEL 7

// Field reset values, largest legal ratio code and reserved ratio bits
`define RST_TMO 3'h3
`define RST_MODE 2'h1
`define RST_RATIO_CODE 6'h03
`define RATIO_CODE_MAX 6'h0D
`define RATIO_RSVD_BITS 2'h1

// Pin modes
`define MODE_LIVE 2'h0
`define MODE_LATCHED 2'h1
`define MODE_ONE_PULSE 2'h2
`define MODE_REPEAT 2'h3

// Live flag count and timing
`define NUM_FLAGS 15
`define CNT_W 20
`define CLK_MHZ 100
`define PULSE_TIME_US 3000
`define PERIOD_TIME_US 4000
`define PULSE_CYCLES (`PULSE_TIME_US * `CLK_MHZ)
`define PERIOD_CYCLES (`PERIOD_TIME_US * `CLK_MHZ)

`endif

/* hdl/fsirq_pkg.sv */
// Types shared by the fault/status block and its pin driver
`include "fsirq_params.svh"
package fsirq_pkg;
	// Phase of the timed pin pulse
	typedef enum logic [1:0] {PH_IDLE, PH_PULSE, PH_GAP} pulse_phase_t;

	// Whole state of the pin driver
	typedef struct packed {
		pulse_phase_t phase;
		logic [`CNT_W-1:0] cnt;
		logic pin;
	} drv_state_t;

	// Whole state of the register block
	typedef struct packed {
		logic [`NUM_FLAGS-1:0] live;
		logic [`NUM_FLAGS-1:0] latched;
		logic [11:0] low_code;
		logic [11:0] high_code;
		logic [7:0] temp;
		logic auto_pwr;
		logic halt_off;
		logic [2:0] tmo;
		logic clr;
		logic [1:0] mode;
		logic lvl_low;
		logic [5:0] ratio;
		logic [7:0] prdata;
		logic pready;
		logic pslverr;
	} ctl_state_t;
endpackage

/* hdl/irq_pin_driver.sv */
// Interrupt pin driver: mode selection, timed pulses and polarity
`timescale 1ns/1ps
`include "fsirq_params.svh"
module irq_pin_driver #(
	parameter int unsigned PULSE_CYCLES = `PULSE_CYCLES,
	parameter int unsigned PERIOD_CYCLES = `PERIOD_CYCLES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Settings
	input wire logic [1:0] mode,
	input wire logic lvl_low,
	// Unmasked conditions
	input wire logic live_any,
	input wire logic latched_any,
	input wire logic live_event,
	// Pin
	output logic pin
);
	fsirq_pkg::drv_state_t st_q; // Registered state
	fsirq_pkg::drv_state_t st_d; // Next state
	logic active; // Pin asserted, before polarity

	// Next state: pulse sequencer and pin level
	always_comb begin
		st_d = st_q;
		active = 1'b0;
		case (st_q.phase)
			fsirq_pkg::PH_IDLE: begin
				// One pulse per event, or a train while anything is latched
				if ((mode == `MODE_ONE_PULSE && live_event) || // RULE17
					(mode == `MODE_REPEAT && latched_any)) begin
					st_d.phase = fsirq_pkg::PH_PULSE;
					st_d.cnt = '0;
				end
			end
			fsirq_pkg::PH_PULSE: begin
				st_d.cnt = st_q.cnt + `CNT_W'(1);
				// Events arriving inside a pulse are absorbed by it
				if (st_q.cnt == `CNT_W'(PULSE_CYCLES - 1)) begin
					st_d.phase = (mode == `MODE_REPEAT) ? fsirq_pkg::PH_GAP : fsirq_pkg::PH_IDLE;
				end
			end
			fsirq_pkg::PH_GAP: begin
				st_d.cnt = st_q.cnt + `CNT_W'(1);
				// Period measured from the start of the last pulse
				if (st_q.cnt == `CNT_W'(PERIOD_CYCLES - 1)) begin
					st_d.cnt = '0;
					st_d.phase = (mode == `MODE_REPEAT && latched_any) ? // RULE17
						fsirq_pkg::PH_PULSE : fsirq_pkg::PH_IDLE;
				end
			end
			default: begin
				st_d.phase = fsirq_pkg::PH_IDLE;
			end
		endcase
		// Level modes never leave the sequencer running
		if (mode == `MODE_LIVE || mode == `MODE_LATCHED) begin
			st_d.phase = fsirq_pkg::PH_IDLE;
		end
		case (mode)
			`MODE_LIVE: active = live_any; // RULE16
			`MODE_LATCHED: active = latched_any; // RULE16
			default: active = (st_d.phase == fsirq_pkg::PH_PULSE); // RULE17
		endcase
		st_d.pin = active ^ lvl_low; // RULE18
	end

	// State register; pin idles high as for the active-low reset polarity
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '{phase: fsirq_pkg::PH_IDLE, cnt: '0, pin: 1'b1};
		end else begin
			st_q <= st_d;
		end
	end

	assign pin = st_q.pin;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Latched level mode
	latched_level_a: assert property (mode == `MODE_LATCHED |=> // RULE16
		pin == ($past(latched_any) ^ $past(lvl_low)))
		else $error("pin does not follow latched condition");
	// Pulse never runs past its length
	pulse_length_a: assert property (st_q.phase == fsirq_pkg::PH_PULSE |-> // RULE17
		st_q.cnt < `CNT_W'(PULSE_CYCLES))
		else $error("pulse longer than its length");
	// Repeat train restarts at the end of the period
	sequence period_end_s;
		st_q.phase == fsirq_pkg::PH_GAP && st_q.cnt == `CNT_W'(PERIOD_CYCLES - 1) &&
		mode == `MODE_REPEAT && latched_any;
	endsequence
	repeat_pulse_a: assert property (period_end_s |=> // RULE17
		st_q.phase == fsirq_pkg::PH_PULSE && pin == !lvl_low)
		else $error("repeat pulse did not restart");
endmodule

/* hdl/fault_status_irq_control.sv */
// Fault status, conversion readback and interrupt pin control with APB access
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "fsirq_params.svh"
// Notes on behaviour
// RULE1: four live over-temperature flags, bits 7-4
// RULE2: regulator and high-supply undervolt; bits 2-1 zero
// RULE3: thermal thresholds two and one, bits 7-6
// RULE4: supply gap low flag in bit 5
// RULE5: brownout active, detected, shutdown in bits 4-2
// RULE6: invalid clock ratio or rate, bit 2
// RULE7: sample rate changed on the fly, bit 1
// RULE8: clock ratio changed on the fly, bit 0
// RULE9: low-supply code split high byte, low nibble
// RULE10: high-supply code split high byte, low nibble
// RULE11: raw temperature code, offset applied by software
// RULE12: auto power by clock presence, reset off
// RULE13: halt detection disable bit, reset enabled
// RULE14: three-bit halt timeout, reset code three
// RULE15: self-clearing write clears all latched flags
// RULE16: pin modes live level and latched level
// RULE17: single pulse per event, repeating pulse train
// RULE18: pin polarity bit, reset active low
// RULE19: manual clock ratio field, reset code three
// RULE20: host avoids reserved ratio codes
// RULE21: live flags track; latched set on rise
// RULE22: status writes ignored, reads have no effects
module fault_status_irq_control #(
	parameter int unsigned PULSE_CYCLES = `PULSE_CYCLES,
	parameter int unsigned PERIOD_CYCLES = `PERIOD_CYCLES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Live thermal and supply conditions
	input wire logic live_over_temp_a,
	input wire logic live_over_temp_b,
	input wire logic live_over_temp_c,
	input wire logic live_over_temp_d,
	input wire logic live_regulator_undervolt,
	input wire logic live_high_supply_undervolt,
	// Live thermal detection and brownout conditions
	input wire logic live_thermal_thresh_two,
	input wire logic live_thermal_thresh_one,
	input wire logic live_supply_gap_low,
	input wire logic live_brownout_active,
	input wire logic live_brownout_detected,
	input wire logic live_brownout_shutdown,
	// Live audio port clock errors
	input wire logic live_clock_invalid,
	input wire logic live_rate_changed,
	input wire logic live_ratio_changed,
	// Converter results
	input wire logic [11:0] low_supply_code,
	input wire logic [11:0] high_supply_code,
	input wire logic [7:0] die_temp_code,
	// Interrupt mask, one bit per flag, 1 lets it through
	input wire logic [14:0] irq_mask,
	// Settings towards the rest of the device
	output logic clock_auto_power,
	output logic halt_detect_off,
	output logic [2:0] halt_timeout_code,
	output logic [5:0] manual_clock_ratio,
	// Latched flags and their clear
	output logic [14:0] latched_flags,
	output logic latch_clear,
	// Interrupt pin
	output logic irq_pin
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	// Reset image of the whole state
	localparam fsirq_pkg::ctl_state_t RST_ST = '{
		live: '0,
		latched: '0,
		low_code: '0,
		high_code: '0,
		temp: '0,
		auto_pwr: 1'b0, // RULE12
		halt_off: 1'b0, // RULE13
		tmo: `RST_TMO, // RULE14
		clr: 1'b0,
		mode: `RST_MODE, // RULE16
		lvl_low: 1'b1, // RULE18
		ratio: `RST_RATIO_CODE, // RULE19
		prdata: '0,
		pready: 1'b0,
		pslverr: 1'b0
	};

	fsirq_pkg::ctl_state_t st_q; // Registered state
	fsirq_pkg::ctl_state_t st_d; // Next state
	logic [`NUM_FLAGS-1:0] live_vec; // Live inputs in flag order
	logic [`NUM_FLAGS-1:0] rise; // Flags that went up this cycle
	logic [9:0] idx; // Register index from the address
	logic setup; // APB setup phase
	logic wr_en; // Write completes at this edge
	logic [7:0] rd_byte; // Read multiplexer output
	logic mapped; // Address hits a register
	logic live_any; // Any unmasked live flag
	logic latched_any; // Any unmasked latched flag
	logic live_event; // Any unmasked live flag rising

	////////////////////////////////////////////////////////////////////////////////
	// Flag collection

	// Flag order matches the three status registers, high bits first
	assign live_vec = {
		live_over_temp_a, live_over_temp_b, live_over_temp_c, live_over_temp_d,
		live_regulator_undervolt, live_high_supply_undervolt,
		live_thermal_thresh_two, live_thermal_thresh_one, live_supply_gap_low,
		live_brownout_active, live_brownout_detected, live_brownout_shutdown,
		live_clock_invalid, live_rate_changed, live_ratio_changed
	};

	// Edge against the registered copy, so one rise is seen once
	assign rise = live_vec & ~st_q.live; // RULE21
	assign live_any = |(st_q.live & irq_mask);
	assign latched_any = |(st_q.latched & irq_mask);
	assign live_event = |(rise & irq_mask);

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode

	// Only word-aligned addresses map to registers
	assign idx = paddr[11:2];
	assign setup = psel && !penable;
	assign wr_en = psel && penable && st_q.pready && pwrite && pstrb[0];

	// Read image of each register; reserved bits as at reset
	always_comb begin
		rd_byte = 8'h00;
		mapped = (paddr[1:0] == 2'h0);
		case (idx)
			`IDX_THERM_SUPPLY: begin
				rd_byte = {st_q.live[14:11], st_q.live[10], 2'h0, st_q.live[9]}; // RULE1 RULE2
			end
			`IDX_THERM_BROWN: begin
				rd_byte = {st_q.live[8:7], st_q.live[6], st_q.live[5:3], 2'h0}; // RULE3 RULE4 RULE5
			end
			`IDX_CLK_ERR: begin
				rd_byte = {5'h00, st_q.live[2], st_q.live[1], st_q.live[0]}; // RULE6 RULE7 RULE8
			end
			`IDX_LOW_CONV_HI: begin
				rd_byte = st_q.low_code[11:4]; // RULE9
			end
			`IDX_LOW_CONV_LO: begin
				rd_byte = {st_q.low_code[3:0], 4'h0}; // RULE9
			end
			`IDX_HIGH_CONV_HI: begin
				rd_byte = st_q.high_code[11:4]; // RULE10
			end
			`IDX_HIGH_CONV_LO: begin
				rd_byte = {st_q.high_code[3:0], 4'h0}; // RULE10
			end
			`IDX_TEMP_CONV: begin
				// Raw code; degrees are the code minus the fixed offset
				rd_byte = st_q.temp; // RULE11
			end
			`IDX_HALT_CTRL: begin
				rd_byte = {st_q.auto_pwr, st_q.halt_off, st_q.tmo, st_q.clr, st_q.mode};
			end
			`IDX_PIN_POL: begin
				rd_byte = {st_q.lvl_low, 7'h00}; // RULE18
			end
			`IDX_RATIO: begin
				rd_byte = {st_q.ratio, `RATIO_RSVD_BITS}; // RULE19
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_d = st_q;
		// Flags and conversions refresh every cycle, reads never touch them
		st_d.live = live_vec; // RULE21 RULE22
		st_d.low_code = low_supply_code;
		st_d.high_code = high_supply_code;
		st_d.temp = die_temp_code;
		// Set beats clear when a rise meets the clear pulse
		st_d.latched = (st_q.latched & ~{`NUM_FLAGS{st_q.clr}}) | rise; // RULE15 RULE21
		// Clear bit lives one cycle only
		st_d.clr = 1'b0; // RULE15

		// Answer prepared in setup, shown through the access phase
		st_d.pready = setup;
		st_d.pslverr = setup && !mapped;
		if (setup) begin
			st_d.prdata = pwrite ? 8'h00 : rd_byte;
		end

		// Writes land only on the control registers; status is read-only
		if (wr_en && mapped) begin // RULE22
			case (idx)
				`IDX_HALT_CTRL: begin
					st_d.auto_pwr = pwdata[`CTRL_AUTO_PWR]; // RULE12
					st_d.halt_off = pwdata[`CTRL_HALT_OFF]; // RULE13
					st_d.tmo = pwdata[`CTRL_TMO_HI:`CTRL_TMO_LO]; // RULE14
					st_d.clr = pwdata[`CTRL_CLR]; // RULE15
					st_d.mode = pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]; // RULE16
				end
				`IDX_PIN_POL: begin
					st_d.lvl_low = pwdata[`POL_LEVEL]; // RULE18
				end
				`IDX_RATIO: begin
					// Reserved codes are dropped so the datapath never sees them
					if (pwdata[7:2] <= `RATIO_CODE_MAX) begin // RULE20
						st_d.ratio = pwdata[7:2]; // RULE19
					end
				end
				default: begin
					st_d.ratio = st_q.ratio;
				end
			endcase
		end
	end

	// Whole state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= RST_ST;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin driver

	irq_pin_driver #(
		.PULSE_CYCLES(PULSE_CYCLES),
		.PERIOD_CYCLES(PERIOD_CYCLES)
	) u_pin (
		.pclk(pclk),
		.presetn(presetn),
		.mode(st_q.mode),
		.lvl_low(st_q.lvl_low),
		.live_any(live_any),
		.latched_any(latched_any),
		.live_event(live_event),
		.pin(irq_pin)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all from the state register

	assign prdata = {24'h000000, st_q.prdata};
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;
	assign clock_auto_power = st_q.auto_pwr;
	assign halt_detect_off = st_q.halt_off;
	assign halt_timeout_code = st_q.tmo;
	assign manual_clock_ratio = st_q.ratio;
	assign latched_flags = st_q.latched;
	assign latch_clear = st_q.clr;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Read setup to a given register
	sequence read_setup_s(logic [9:0] r);
		psel && !penable && !pwrite && paddr == {r, 2'h0};
	endsequence

	live_follow_a: assert property (##1 st_q.live == $past(live_vec)) // RULE1
		else $error("live flags lag their inputs");
	supply_reserved_a: assert property (read_setup_s(`IDX_THERM_SUPPLY) |=> // RULE2
		prdata[2:1] == 2'h0 && prdata[0] == $past(st_q.live[9]))
		else $error("supply status reserved bits not zero");
	low_split_a: assert property (read_setup_s(`IDX_LOW_CONV_LO) |=> // RULE9
		prdata[7:4] == $past(st_q.low_code[3:0]) && prdata[3:0] == 4'h0)
		else $error("low supply low nibble misplaced");
	latch_set_a: assert property (|rise |=> // RULE21
		(st_q.latched & $past(rise)) == $past(rise))
		else $error("rising flag not latched");
	clear_self_a: assert property (st_q.clr |=> !st_q.clr) // RULE15
		else $error("latch clear did not return to zero");
	clear_effect_a: assert property (st_q.clr && rise == '0 |=> st_q.latched == '0) // RULE15
		else $error("latched flags not cleared");
	ratio_legal_a: assert property (st_q.ratio <= `RATIO_CODE_MAX) // RULE20
		else $error("reserved clock ratio code stored");
	tmo_write_a: assert property (wr_en && idx == `IDX_HALT_CTRL && paddr[1:0] == 2'h0 |=> // RULE14
		halt_timeout_code == $past(pwdata[5:3]))
		else $error("halt timeout write lost");
endmodule

/* verif/apb_host_model.sv */
// Host processor model: APB master that reads flags and writes controls
`timescale 1ns/1ps
`include "fsirq_params.svh"
module apb_host (
	// Clock
	input wire logic pclk,
	// APB master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
	end

	////////////////////////////////////////////////////////////////////////////
	// One transfer; the request holds until pready is seen at an edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [7:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= 4'hF;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for the answer; only the bench timeout ends a dead wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines flip so a stale value never looks valid
		paddr <= ~a;
		pwdata <= ~{24'h0, d};
	endtask

	// Acknowledge: set the self-clearing bit on top of the settings
	task automatic clear_latches(input logic [7:0] ctrl);
		logic [7:0] r;
		logic e;
		xfer(1'b1, {`IDX_HALT_CTRL, 2'b00}, ctrl | 8'h04, r, e);
	endtask

	// Ratio write; reserved codes are never sent
	task automatic set_ratio(input logic [5:0] code);
		logic [7:0] r;
		logic e;
		if (code > `RATIO_CODE_MAX) begin
			code = `RATIO_CODE_MAX;
		end
		xfer(1'b1, {`IDX_RATIO, 2'b00}, {code, 2'b00}, r, e);
	endtask
endmodule

/* verif/tb_fault_status_irq_control.sv */
// Self-checking bench for the fault status and interrupt pin block
`timescale 1ns/1ps
`include "fsirq_params.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin miscompares++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_fault_status_irq_control;
	// Short pulse timing keeps the run brief
	localparam int PC = 20;
	localparam int PP = 30;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	// Live conditions, order as the latched vector
	logic [14:0] lv = 15'h0;
	logic [14:0] mask = 15'h0;
	logic [11:0] lo_c = 12'h000;
	logic [11:0] hi_c = 12'h000;
	logic [7:0] tc = 8'h00;
	logic cap, hdo, lclr, irq;
	logic [2:0] htc;
	logic [5:0] mcr;
	logic [14:0] lf;
	logic [7:0] rv, d;
	logic er;
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;
	int cnt;
	logic [9:0] ix [11] = '{`IDX_THERM_SUPPLY, `IDX_THERM_BROWN, `IDX_CLK_ERR,
		`IDX_LOW_CONV_HI, `IDX_LOW_CONV_LO, `IDX_HIGH_CONV_HI, `IDX_HIGH_CONV_LO,
		`IDX_TEMP_CONV, `IDX_HALT_CTRL, `IDX_PIN_POL, `IDX_RATIO};
	logic [7:0] rs [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h19, 8'h80, 8'h0D};

	// 100 MHz clock
	always #5 pclk = ~pclk;

	////////////////////////////////////////////////////////////////////////////
	// Design and host
	fault_status_irq_control #(.PULSE_CYCLES(PC), .PERIOD_CYCLES(PP)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.live_over_temp_a(lv[14]), .live_over_temp_b(lv[13]), .live_over_temp_c(lv[12]),
		.live_over_temp_d(lv[11]), .live_regulator_undervolt(lv[10]),
		.live_high_supply_undervolt(lv[9]), .live_thermal_thresh_two(lv[8]),
		.live_thermal_thresh_one(lv[7]), .live_supply_gap_low(lv[6]),
		.live_brownout_active(lv[5]), .live_brownout_detected(lv[4]),
		.live_brownout_shutdown(lv[3]), .live_clock_invalid(lv[2]),
		.live_rate_changed(lv[1]), .live_ratio_changed(lv[0]),
		.low_supply_code(lo_c), .high_supply_code(hi_c), .die_temp_code(tc),
		.irq_mask(mask), .clock_auto_power(cap), .halt_detect_off(hdo),
		.halt_timeout_code(htc), .manual_clock_ratio(mcr), .latched_flags(lf),
		.latch_clear(lclr), .irq_pin(irq));
	apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	////////////////////////////////////////////////////////////////////////////
	// Expected status and conversion bytes from the driven conditions
	function automatic logic [7:0] exp_reg(input logic [9:0] i);
		case (i)
			`IDX_THERM_SUPPLY: return {lv[14:10], 2'b00, lv[9]};
			`IDX_THERM_BROWN: return {lv[8:3], 2'b00};
			`IDX_CLK_ERR: return {5'h00, lv[2:0]};
			`IDX_LOW_CONV_HI: return lo_c[11:4];
			`IDX_LOW_CONV_LO: return {lo_c[3:0], 4'h0};
			`IDX_HIGH_CONV_HI: return hi_c[11:4];
			`IDX_HIGH_CONV_LO: return {hi_c[3:0], 4'h0};
			default: return tc;
		endcase
	endfunction

	// Register access by index
	task automatic rd(input logic [9:0] i);
		host.xfer(1'b0, {i, 2'b00}, 8'h00, rv, er);
	endtask
	task automatic wr(input logic [9:0] i, input logic [7:0] v);
		host.xfer(1'b1, {i, 2'b00}, v, rv, er);
	endtask

	// Wait for the pin to go high, then count high cycles over three periods
	task automatic pulse_count();
		int n;
		n = 0;
		cnt = 0;
		// Settle past the launching edge so a pulse started there is counted
		#1;
		while (irq !== 1'b1 && n < 100) begin
			@(posedge pclk);
			#1;
			n++;
		end
		for (int j = 0; j < 3 * PP; j++) begin
			if (irq === 1'b1) cnt++;
			@(posedge pclk);
			#1;
		end
	endtask

	// Verdict
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Hang guard, well above the expected run length
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		void'($urandom(32'h167ebf60));
		// Reset values of every register and setting output
		`CHK("pin idle", 1'b1, irq)
		`CHK("timeout code", 3'h3, htc)
		`CHK("ratio out", 6'h03, mcr)
		`CHK("auto power", 1'b0, cap)
		`CHK("halt off", 1'b0, hdo)
		for (int k = 0; k < 11; k++) begin
			rd(ix[k]);
			`CHK("reset value", rs[k], rv)
			`CHK("mapped no error", 1'b0, er)
		end
		$display("test reset done");
		// Status and supply conversions, all-ones first then random, temperature always random; writes ignored
		for (int n = 0; n < 12; n++) begin
			@(posedge pclk);
			lv <= (n == 0) ? 15'h7FFF : 15'($urandom);
			lo_c <= (n == 0) ? 12'hFFF : 12'($urandom);
			hi_c <= (n == 0) ? 12'hFFF : 12'($urandom);
			tc <= 8'($urandom);
			repeat (2) @(posedge pclk);
			for (int k = 0; k < 8; k++) begin
				wr(ix[k], 8'($urandom));
				rd(ix[k]);
				`CHK("status", exp_reg(ix[k]), rv)
			end
		end
		host.xfer(1'b0, {10'h057, 2'b00}, 8'h00, rv, er);
		`CHK("unmapped error", 1'b1, er)
		host.xfer(1'b1, {`IDX_HALT_CTRL, 2'b01}, 8'hFF, rv, er);
		`CHK("misaligned error", 1'b1, er)
		$display("test status done");
		// Control fields over every timeout code
		for (int t = 0; t < 8; t++) begin
			d = {1'($urandom), 1'($urandom), 3'(t), 3'h1};
			wr(`IDX_HALT_CTRL, d);
			rd(`IDX_HALT_CTRL);
			`CHK("control", d, rv)
			`CHK("auto power", d[7], cap)
			`CHK("halt off", d[6], hdo)
			`CHK("timeout code", 3'(t), htc)
		end
		// Every legal ratio code
		for (int c = 0; c < 14; c++) begin
			host.set_ratio(6'(c));
			rd(`IDX_RATIO);
			`CHK("ratio", {6'(c), 2'b01}, rv)
			`CHK("ratio out", 6'(c), mcr)
		end
		$display("test control done");
		// Latched mode, active low: a one-cycle condition is held until cleared
		@(posedge pclk);
		lv <= 15'h0;
		host.clear_latches(8'h19);
		mask <= 15'h7FFF;
		repeat (3) @(posedge pclk);
		`CHK("pin idle", 1'b1, irq)
		@(posedge pclk);
		lv <= 15'h1000;
		@(posedge pclk);
		lv <= 15'h0;
		repeat (3) @(posedge pclk);
		`CHK("latched", 15'h1000, lf)
		`CHK("pin latched", 1'b0, irq)
		rd(`IDX_THERM_SUPPLY);
		`CHK("live gone", 8'h00, rv)
		host.clear_latches(8'h19);
		@(posedge pclk);
		`CHK("clear pulse", 1'b1, lclr)
		repeat (2) @(posedge pclk);
		`CHK("clear pulse end", 1'b0, lclr)
		`CHK("cleared", 15'h0, lf)
		`CHK("pin released", 1'b1, irq)
		rd(`IDX_HALT_CTRL);
		`CHK("clear bit back", 8'h19, rv)
		// Live mode, active high: pin follows the condition, not the latch
		wr(`IDX_PIN_POL, 8'h00);
		rd(`IDX_PIN_POL);
		`CHK("polarity", 8'h00, rv)
		wr(`IDX_HALT_CTRL, 8'h18);
		@(posedge pclk);
		lv <= 15'h0001;
		repeat (3) @(posedge pclk);
		`CHK("pin live on", 1'b1, irq)
		lv <= 15'h0;
		repeat (3) @(posedge pclk);
		`CHK("pin live off", 1'b0, irq)
		// A masked condition must not reach the pin
		mask <= 15'h7FFE;
		lv <= 15'h0001;
		repeat (3) @(posedge pclk);
		`CHK("pin masked", 1'b0, irq)
		lv <= 15'h0;
		repeat (2) @(posedge pclk);
		mask <= 15'h7FFF;
		$display("test level modes done");
		// One pulse per event, then repeating pulses while latched
		wr(`IDX_HALT_CTRL, 8'h1A);
		host.clear_latches(8'h1A);
		@(posedge pclk);
		lv <= 15'h0002;
		@(posedge pclk);
		lv <= 15'h0;
		pulse_count();
		`CHK("single pulse cycles", PC, cnt)
		wr(`IDX_HALT_CTRL, 8'h1B);
		pulse_count();
		`CHK("pulse train cycles", 3 * PC, cnt)
		host.clear_latches(8'h1B);
		repeat (PP + 2) @(posedge pclk);
		`CHK("train stopped", 1'b0, irq)
		$display("test pulse modes done");
		complete_run();
	end
endmodule
